// [core/hs_homing_sequencer.sv]
// What this block does
// - Method 14: reverse at switch speed, switch off then zero speed onward.
// - Home switch on at start: leave it at switch speed, then zero speed.
// - Switch-and-index methods take the first index at zero speed as home.
// - Method 14: negative limit stops motion, then forward at switch speed.
// - After the limit, switch on: zero speed and reverse before index search.
// - Methods 11 to 13 run the 14 sequence, 12 and 13 with inverted switch polarity.
// - Method 24: forward, home latched where the home switch turns on.
// - Method 28: reverse, home latched where the home switch turns on.
// - Methods 33 and 34: index search at zero speed, reverse or forward.
// - Method 35: current position becomes home with no motion.
// - Methods -1,-2: dwell at stopper, reverse, take first index at zero speed.
// - Methods -3,-4: dwell at stopper, then home there with no index.
// - Methods -1 and -3 start reverse at switch speed.
// - Methods -2 and -4 start forward at switch speed.
// - Methods -5,-6: home switch on stops motion and completes homing.
// - Methods -5,-6: any limit raises homing error and stops.
// - Method -5 starts reverse, -6 forward, at switch speed.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
module hs_homing_sequencer
	import hs_pkg::*;
#(
	parameter int unsigned TICK_CYC = DWELL_UNIT_CYC
) (
	input  wire logic                core_clk_in,
	input  wire logic                rst_in,
	input  wire logic                hsel_in,
	input  wire logic [ADDR_W-1:0]   haddr_in,
	input  wire logic [1:0]          htrans_in,
	input  wire logic                hwrite_in,
	input  wire logic [2:0]          hsize_in,
	input  wire logic [31:0]         hwdata_in,
	input  wire logic                hready_in,
	output logic                     hreadyout_out,
	output logic                     hresp_out,
	output logic [31:0]              hrdata_out,
	input  wire hs_sense_s           sense_in,
	output hs_motion_s               motion_out,
	output logic                     busy_out,
	output logic                     done_out,
	output logic                     err_out
);
	// ---------------- bus slave ----------------
	logic [7:0]  method_reg;
	logic [31:0] sw_spd_reg;
	logic [31:0] zero_spd_reg;
	logic [15:0] stopper_torque_limit_reg;
	logic [15:0] stopper_dwell_time_reg;
	logic [31:0] home_pos_reg;
	logic        done_reg;
	logic        err_reg;
	logic        start_reg;
	logic        wr_pend_reg;
	logic [15:0] wr_idx_reg;
	logic [31:0] hrdata_reg;
	hs_state_e   state_reg;
	hs_state_e   state_next;

	logic        addr_ok;
	logic [15:0] acc_idx;
	logic [31:0] rd_mux;

	assign addr_ok = hsel_in && hready_in && htrans_in[1] && hsize_in == 3'h2;
	assign acc_idx = haddr_in[17:2];

	always_comb begin
		unique case (acc_idx)
			IDX_CTRL:     rd_mux = {24'h00_0000, method_reg};
			IDX_SW_SPD:   rd_mux = sw_spd_reg;
			IDX_ZERO_SPD: rd_mux = zero_spd_reg;
			IDX_STATUS:   rd_mux = {14'h0000, state_reg, 5'h00, err_reg, done_reg,
				state_reg != S_IDLE};
			IDX_HOME_POS: rd_mux = home_pos_reg;
			IDX_TORQ:     rd_mux = {16'h0000, stopper_torque_limit_reg};
			IDX_DWELL:    rd_mux = {16'h0000, stopper_dwell_time_reg};
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	// read data is sampled at the address phase and stands in the data phase
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (addr_ok && !hwrite_in) begin
			hrdata_reg <= rd_mux;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 16'h0000;
		end else if (hready_in) begin
			wr_pend_reg <= addr_ok && hwrite_in;
			wr_idx_reg  <= acc_idx;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			method_reg   <= RST_METHOD;
			sw_spd_reg   <= RST_SPEED;
			zero_spd_reg <= RST_SPEED;
			stopper_torque_limit_reg <= RST_TORQ;
			stopper_dwell_time_reg   <= RST_DWELL;
		end else if (wr_pend_reg) begin
			unique case (wr_idx_reg)
				IDX_CTRL:     method_reg   <= hwdata_in[CTRL_METHOD_LSB +: 8];
				IDX_SW_SPD:   sw_spd_reg   <= hwdata_in;
				IDX_ZERO_SPD: zero_spd_reg <= hwdata_in;
				IDX_TORQ:     stopper_torque_limit_reg <= hwdata_in[15:0];
				IDX_DWELL:    stopper_dwell_time_reg   <= hwdata_in[15:0];
				default:      ;
			endcase
		end
	end

	// start is a one-cycle pulse, ignored unless idle
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			start_reg <= 1'b0;
		end else begin
			start_reg <= wr_pend_reg && wr_idx_reg == IDX_CTRL && hwdata_in[CTRL_START_BIT];
		end
	end

	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign hrdata_out    = hrdata_reg;

	// ---------------- method decode ----------------
	logic m_valid;
	logic m_sw_idx;
	logic m_sw_only;
	logic m_idx_only;
	logic m_here;
	logic m_stop_idx;
	logic m_stop_only;
	logic m_sw_stop;
	logic m_rev;
	logic m_inv;

	always_comb begin
		m_sw_idx    = 1'b0;
		m_sw_only   = 1'b0;
		m_idx_only  = 1'b0;
		m_here      = 1'b0;
		m_stop_idx  = 1'b0;
		m_stop_only = 1'b0;
		m_sw_stop   = 1'b0;
		m_rev       = 1'b0;
		m_inv       = 1'b0;
		unique case (method_reg)
			M_11, M_14: begin
				m_sw_idx = 1'b1;
				m_rev    = 1'b1;
			end
			M_12, M_13: begin
				m_sw_idx = 1'b1;
				m_rev    = 1'b1;
				m_inv    = 1'b1;
			end
			M_24: m_sw_only = 1'b1;
			M_28: begin
				m_sw_only = 1'b1;
				m_rev     = 1'b1;
			end
			M_33: begin
				m_idx_only = 1'b1;
				m_rev      = 1'b1;
			end
			M_34: m_idx_only = 1'b1;
			M_35: m_here     = 1'b1;
			M_N1: begin
				m_stop_idx = 1'b1;
				m_rev      = 1'b1;
			end
			M_N2: m_stop_idx = 1'b1;
			M_N3: begin
				m_stop_only = 1'b1;
				m_rev       = 1'b1;
			end
			M_N4: m_stop_only = 1'b1;
			M_N5: begin
				m_sw_stop = 1'b1;
				m_rev     = 1'b1;
			end
			M_N6: m_sw_stop = 1'b1;
			default: ;
		endcase
	end

	assign m_valid = m_sw_idx | m_sw_only | m_idx_only | m_here | m_stop_idx | m_stop_only
		| m_sw_stop;

	// ---------------- sequencer ----------------
	logic dir_rev_reg;
	logic dir_rev_next;
	logic inv_reg;
	logic home_act;
	logic lim_ahead;
	logic any_lim;
	logic cap_ev;
	logic done_ev;
	logic err_ev;
	logic dwell_done;

	assign home_act  = sense_in.home_sw ^ inv_reg;
	assign lim_ahead = dir_rev_reg ? sense_in.neg_limit : sense_in.pos_limit_input;
	assign any_lim   = sense_in.neg_limit | sense_in.pos_limit_input;

	hs_dwell_timer #(
		.TICK_CYC (TICK_CYC)
	) u_dwell (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.run_in      (state_reg == S_STOPPER),
		.over_in     (sense_in.torque >= stopper_torque_limit_reg),
		.dwell_in    (stopper_dwell_time_reg),
		.expired_out (dwell_done)
	);

	always_comb begin
		state_next   = state_reg;
		dir_rev_next = dir_rev_reg;
		cap_ev       = 1'b0;
		done_ev      = 1'b0;
		err_ev       = 1'b0;
		unique case (state_reg)
			S_IDLE: if (start_reg) begin
				dir_rev_next = m_rev;
				if (!m_valid) begin
					err_ev = 1'b1;
				end else if (m_here) begin
					cap_ev  = 1'b1;
					done_ev = 1'b1;
				end else if (m_idx_only) begin
					state_next = S_SEEK_IDX;
				end else if (m_stop_idx || m_stop_only) begin
					state_next = S_STOPPER;
				end else if (m_sw_idx && (sense_in.home_sw ^ m_inv)) begin
					state_next = S_LEAVE_SW;
				end else begin
					state_next = S_SEEK_SW;
				end
			end
			S_SEEK_SW: if (m_sw_stop && any_lim) begin
				err_ev     = 1'b1;
				state_next = S_STOP_ERR;
			end else if (lim_ahead) begin
				state_next = S_LIM_STOP;
			end else if (home_act) begin
				if (m_sw_idx) begin
					state_next = S_LEAVE_SW;
				end else begin
					cap_ev     = 1'b1;
					state_next = S_STOP_OK;
				end
			end
			S_LEAVE_SW: if (lim_ahead) begin
				state_next = S_LIM_STOP;
			end else if (!home_act) begin
				state_next = S_SEEK_IDX;
			end
			S_LIM_STOP: if (sense_in.standstill) begin
				dir_rev_next = !dir_rev_reg;
				state_next   = S_BACK_SW;
			end
			S_BACK_SW: if (lim_ahead) begin
				err_ev     = 1'b1;
				state_next = S_STOP_ERR;
			end else if (home_act) begin
				if (m_sw_idx) begin
					dir_rev_next = !dir_rev_reg;
					state_next   = S_SEEK_IDX;
				end else begin
					cap_ev     = 1'b1;
					state_next = S_STOP_OK;
				end
			end
			S_SEEK_IDX: if (sense_in.index) begin
				cap_ev     = 1'b1;
				state_next = S_GOTO;
			end else if (lim_ahead) begin
				err_ev     = 1'b1;
				state_next = S_STOP_ERR;
			end
			S_GOTO: if (sense_in.standstill && sense_in.position == home_pos_reg) begin
				done_ev    = 1'b1;
				state_next = S_IDLE;
			end
			S_STOPPER: if (dwell_done) begin
				if (m_stop_idx) begin
					dir_rev_next = !dir_rev_reg;
					state_next   = S_SEEK_IDX;
				end else begin
					cap_ev     = 1'b1;
					done_ev    = 1'b1;
					state_next = S_IDLE;
				end
			end
			S_STOP_OK: if (sense_in.standstill) begin
				done_ev    = 1'b1;
				state_next = S_IDLE;
			end
			S_STOP_ERR: if (sense_in.standstill) begin
				state_next = S_IDLE;
			end
			default: state_next = S_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_reg   <= S_IDLE;
			dir_rev_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			dir_rev_reg <= dir_rev_next;
		end
	end

	// polarity is frozen for the whole attempt
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			inv_reg <= 1'b0;
		end else if (state_reg == S_IDLE && start_reg) begin
			inv_reg <= m_inv;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			home_pos_reg <= 32'h0000_0000;
		end else if (cap_ev) begin
			home_pos_reg <= sense_in.position;
		end
	end

	// a new start clears the flags, an event in the same cycle still sets them
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			done_reg <= 1'b0;
			err_reg  <= 1'b0;
		end else begin
			done_reg <= (done_reg && !start_reg) || done_ev;
			err_reg  <= (err_reg && !start_reg) || err_ev;
		end
	end

	// motion command follows the next state so it changes with the state
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			motion_out <= '0;
		end else begin
			motion_out.rev           <= dir_rev_next;
			motion_out.move          <= 1'b0;
			motion_out.speed         <= 32'h0000_0000;
			motion_out.torque_lim_en <= state_next == S_STOPPER;
			motion_out.torque_lim    <= stopper_torque_limit_reg;
			motion_out.pos_move      <= state_next == S_GOTO;
			motion_out.target        <= cap_ev ? sense_in.position : home_pos_reg;
			unique case (state_next)
				S_SEEK_SW, S_LEAVE_SW, S_BACK_SW, S_STOPPER: begin
					motion_out.move  <= 1'b1;
					motion_out.speed <= sw_spd_reg;
				end
				S_SEEK_IDX: begin
					motion_out.move  <= 1'b1;
					motion_out.speed <= zero_spd_reg;
				end
				S_GOTO: motion_out.speed <= zero_spd_reg;
				default: ;
			endcase
		end
	end

	assign busy_out = state_reg != S_IDLE;
	assign done_out = done_reg;
	assign err_out  = err_reg;
endmodule

// [core/hs_pkg.sv]
package hs_pkg;
	localparam int unsigned ADDR_W = 18;

	// register indices, byte address is four times the index
	localparam logic [15:0] IDX_CTRL     = 16'h2400;
	localparam logic [15:0] IDX_SW_SPD   = 16'h2401;
	localparam logic [15:0] IDX_ZERO_SPD = 16'h2402;
	localparam logic [15:0] IDX_STATUS   = 16'h2403;
	localparam logic [15:0] IDX_HOME_POS = 16'h2404;
	localparam logic [15:0] IDX_TORQ     = 16'h2409;
	localparam logic [15:0] IDX_DWELL    = 16'h240A;

	// control fields
	localparam int unsigned CTRL_METHOD_LSB = 0;
	localparam int unsigned CTRL_START_BIT  = 8;
	// status fields
	localparam int unsigned ST_BUSY_BIT  = 0;
	localparam int unsigned ST_DONE_BIT  = 1;
	localparam int unsigned ST_ERR_BIT   = 2;
	localparam int unsigned ST_STATE_LSB = 8;

	localparam logic [7:0]  RST_METHOD   = 8'h00;
	localparam logic [31:0] RST_SPEED    = 32'h0000_0000;
	localparam logic [15:0] RST_TORQ     = 16'h0064;
	localparam logic [15:0] RST_DWELL    = 16'h0032;

	// the dwell setting counts in milliseconds
	localparam int unsigned CLK_PERIOD_NS  = 40;
	localparam int unsigned DWELL_UNIT_NS  = 1000000;
	localparam int unsigned DWELL_UNIT_CYC = (DWELL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] M_11 = 8'h0B;
	localparam logic [7:0] M_12 = 8'h0C;
	localparam logic [7:0] M_13 = 8'h0D;
	localparam logic [7:0] M_14 = 8'h0E;
	localparam logic [7:0] M_24 = 8'h18;
	localparam logic [7:0] M_28 = 8'h1C;
	localparam logic [7:0] M_33 = 8'h21;
	localparam logic [7:0] M_34 = 8'h22;
	localparam logic [7:0] M_35 = 8'h23;
	localparam logic [7:0] M_N1 = 8'hFF;
	localparam logic [7:0] M_N2 = 8'hFE;
	localparam logic [7:0] M_N3 = 8'hFD;
	localparam logic [7:0] M_N4 = 8'hFC;
	localparam logic [7:0] M_N5 = 8'hFB;
	localparam logic [7:0] M_N6 = 8'hFA;

	typedef enum logic [9:0] {
		S_IDLE     = 10'h001,
		S_SEEK_SW  = 10'h002,
		S_LEAVE_SW = 10'h004,
		S_LIM_STOP = 10'h008,
		S_BACK_SW  = 10'h010,
		S_SEEK_IDX = 10'h020,
		S_GOTO     = 10'h040,
		S_STOPPER  = 10'h080,
		S_STOP_OK  = 10'h100,
		S_STOP_ERR = 10'h200
	} hs_state_e;

	typedef struct packed {
		logic        pos_limit_input;
		logic        neg_limit;
		logic        home_sw;
		logic        index;
		logic        standstill;
		logic [15:0] torque;
		logic [31:0] position;
	} hs_sense_s;

	typedef struct packed {
		logic        move;
		logic        rev;
		logic [31:0] speed;
		logic        torque_lim_en;
		logic [15:0] torque_lim;
		logic        pos_move;
		logic [31:0] target;
	} hs_motion_s;
endpackage

// [core/hs_dwell_timer.sv]
`timescale 1ns/1ps
module hs_dwell_timer
	import hs_pkg::*;
#(
	parameter int unsigned TICK_CYC = DWELL_UNIT_CYC
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	input  wire logic        run_in,
	input  wire logic        over_in,
	input  wire logic [15:0] dwell_in,
	output logic             expired_out
);
	// the tick counter is 24 bits wide
	if (TICK_CYC < 1 || TICK_CYC > 32'h00FF_FFFF) begin
		$error("hs_dwell_timer: TICK_CYC out of range");
	end

	logic [23:0] tick_reg;
	logic [15:0] units_reg;
	logic        expired_reg;

	// counts only while pressed against the stopper at the torque limit
	always_ff @(posedge core_clk_in) begin
		if (rst_in || !run_in || !over_in) begin
			tick_reg <= 24'h00_0000;
		end else if (tick_reg == 24'(TICK_CYC - 1)) begin
			tick_reg <= 24'h00_0000;
		end else begin
			tick_reg <= tick_reg + 24'h00_0001;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in || !run_in || !over_in) begin
			units_reg <= 16'h0000;
		end else if (tick_reg == 24'(TICK_CYC - 1) && units_reg != 16'hFFFF) begin
			units_reg <= units_reg + 16'h0001;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in || !run_in) begin
			expired_reg <= 1'b0;
		end else begin
			expired_reg <= over_in && (units_reg >= dwell_in);
		end
	end

	assign expired_out = expired_reg;
endmodule

// [bench/hs_homing_props.sv]
`timescale 1ns/1ps
module hs_homing_props
	import hs_pkg::*;
#(
	parameter int unsigned TICK_CYC = DWELL_UNIT_CYC
) (
	input wire logic       core_clk_in,
	input wire logic       rst_in,
	input wire logic       hreadyout_out,
	input wire logic       hresp_out,
	input wire hs_sense_s  sense_in,
	input wire hs_motion_s motion_out,
	input wire logic       busy_out,
	input wire logic       done_out,
	input wire logic       err_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	AST_BUS_OK: assert property (hreadyout_out && !hresp_out)
		else $error("bus answer is not zero-wait OKAY");
	AST_RESET_QUIET: assert property (disable iff (1'b0) rst_in |=>
		motion_out == '0 && !busy_out && !done_out && !err_out)
		else $error("outputs not cleared by reset");
	AST_MOVE_BUSY: assert property (motion_out.move |-> busy_out)
		else $error("motion commanded while idle");
	AST_TLIM_BUSY: assert property (motion_out.torque_lim_en |-> busy_out)
		else $error("torque limit left on while idle");
	AST_DONE_STOP: assert property ($rose(done_out) |-> !motion_out.move)
		else $error("done raised while still moving");
	AST_ERR_STOP: assert property ($rose(err_out) |->
		!motion_out.move && !motion_out.pos_move)
		else $error("error raised without stopping");
	AST_NEG_LIM: assert property (motion_out.move && motion_out.rev &&
		sense_in.neg_limit |=> !(motion_out.move && motion_out.rev))
		else $error("reverse motion kept at negative limit");
	AST_POS_LIM: assert property (motion_out.move && !motion_out.rev &&
		sense_in.pos_limit_input |=> !(motion_out.move && !motion_out.rev))
		else $error("forward motion kept at positive limit");
	AST_IDX_HOLD: assert property (motion_out.pos_move &&
		$past(motion_out.pos_move) |-> $stable(motion_out.target))
		else $error("index target changed during approach");

	cover property ($rose(done_out));
	cover property ($rose(err_out));
	cover property ($rose(motion_out.pos_move));
endmodule

bind hs_homing_sequencer hs_homing_props #(.TICK_CYC(TICK_CYC)) u_props (
	.core_clk_in,
	.rst_in,
	.hreadyout_out,
	.hresp_out,
	.sense_in,
	.motion_out,
	.busy_out,
	.done_out,
	.err_out
);

// [bench/hs_axis_model.sv]
`timescale 1ns/1ps
module hs_axis_model
	import hs_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        load_in,
	input  wire logic [31:0] load_pos_in,
	input  wire logic [31:0] home_lo_in,
	input  wire logic [31:0] home_hi_in,
	input  wire logic [31:0] nlim_in,
	input  wire logic [31:0] plim_in,
	input  wire logic [31:0] nstop_in,
	input  wire logic [31:0] pstop_in,
	input  wire hs_motion_s  motion_in,
	output hs_sense_s        sense_out
);
	logic [31:0] pos_reg;
	logic        blocked;
	logic        seeking;

	// a stopper holds the axis and the torque rises while pushing on it
	assign blocked = motion_in.move && (motion_in.rev ? pos_reg <= nstop_in : pos_reg >= pstop_in);
	assign seeking = motion_in.pos_move && pos_reg != motion_in.target;

	always_ff @(posedge core_clk_in) begin
		if (load_in) begin
			pos_reg <= load_pos_in;
		end else if (motion_in.move && !blocked) begin
			pos_reg <= motion_in.rev ? pos_reg - 32'h1 : pos_reg + 32'h1;
		end else if (seeking) begin
			pos_reg <= pos_reg < motion_in.target ? pos_reg + 32'h1 : pos_reg - 32'h1;
		end
	end

	assign sense_out.pos_limit_input = pos_reg >= plim_in;
	assign sense_out.neg_limit       = pos_reg <= nlim_in;
	assign sense_out.home_sw         = pos_reg >= home_lo_in && pos_reg < home_hi_in;
	assign sense_out.index           = pos_reg[4:0] == 5'h00;
	assign sense_out.standstill      = !motion_in.move && !seeking;
	assign sense_out.torque          = blocked ? 16'hFFFF : 16'h0000;
	assign sense_out.position        = pos_reg;
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench
	import hs_pkg::*;
;
	localparam int unsigned TICK = 4;
	localparam logic [31:0] Z    = 32'h0;
	localparam logic [31:0] T    = 32'hFFFF_FFFF;
	localparam logic [31:0] SS   = 32'h100;
	localparam logic [31:0] ZS   = 32'h20;

	logic              core_clk_in, rst_in, hsel, hwrite, ld, hreadyout, hresp, busy, done, err;
	logic [ADDR_W-1:0] haddr;
	logic [1:0]        htrans;
	logic [2:0]        hsize;
	logic [31:0]       hwdata, hrdata, hlo, hhi, nl, pl, ns, ps, rdv;
	hs_sense_s         sense;
	hs_motion_s        motion;
	int                bad_count, checks, cyc;

	hs_homing_sequencer #(.TICK_CYC(TICK)) dut (
		.core_clk_in   (core_clk_in),
		.rst_in        (rst_in),
		.hsel_in       (hsel),
		.haddr_in      (haddr),
		.htrans_in     (htrans),
		.hwrite_in     (hwrite),
		.hsize_in      (hsize),
		.hwdata_in     (hwdata),
		.hready_in     (hreadyout),
		.hreadyout_out (hreadyout),
		.hresp_out     (hresp),
		.hrdata_out    (hrdata),
		.sense_in      (sense),
		.motion_out    (motion),
		.busy_out      (busy),
		.done_out      (done),
		.err_out       (err)
	);

	hs_axis_model u_axis (
		.core_clk_in (core_clk_in),
		.load_in     (ld),
		.load_pos_in (32'h3E8),
		.home_lo_in  (hlo),
		.home_hi_in  (hhi),
		.nlim_in     (nl),
		.plim_in     (pl),
		.nstop_in    (ns),
		.pstop_in    (ps),
		.motion_in   (motion),
		.sense_out   (sense)
	);

	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge core_clk_in) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			close_out();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d);
		@(posedge core_clk_in);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {idx, 2'b00};
		@(posedge core_clk_in);
		while (hreadyout !== 1'b1) @(posedge core_clk_in);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge core_clk_in);
		while (hreadyout !== 1'b1) @(posedge core_clk_in);
		rdv = hrdata;
	endtask

	// reload the axis at 0x3E8 and place switches, limits and stoppers
	task automatic env(input logic [31:0] lo, hi, n, p, sn, sp);
		@(posedge core_clk_in);
		ld <= 1'b1;
		hlo <= lo;
		hhi <= hi;
		nl <= n;
		pl <= p;
		ns <= sn;
		ps <= sp;
		@(posedge core_clk_in);
		ld <= 1'b0;
	endtask

	// start a method, check the first motion, then flags and home position
	task automatic run(input logic [7:0] m, input logic mv, rv, input logic [31:0] sp,
		input logic dn, er, input logic [31:0] hp);
		int n;
		bus(1'b1, IDX_CTRL, {24'h000001, m});
		repeat (2) @(posedge core_clk_in);
		#1;
		if (mv) begin
			cmp({30'h0, motion.move, motion.rev}, {30'h0, 1'b1, rv});
			cmp(motion.speed, sp);
		end
		n = 0;
		while (busy !== 1'b0 && n < 4000) begin
			@(posedge core_clk_in);
			n++;
		end
		#1;
		cmp({29'h0, busy, err, done}, {29'h0, 1'b0, er, dn});
		if (dn && hp !== T) begin
			bus(1'b0, IDX_HOME_POS, Z);
			cmp(rdv, hp);
		end
	endtask

	initial begin
		rst_in = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = '0;
		hsize = 3'b010;
		hwdata = Z;
		ld = 1'b1;
		{hlo, hhi, nl, ns} = {Z, Z, Z, Z};
		{pl, ps} = {T, T};
		bad_count = 0;
		checks = 0;
		cyc = 0;
		repeat (10) @(posedge core_clk_in);
		rst_in <= 1'b0;
		ld <= 1'b0;
		bus(1'b0, IDX_TORQ, Z);
		cmp(rdv, 32'h64);
		bus(1'b0, IDX_DWELL, Z);
		cmp(rdv, 32'h32);
		bus(1'b1, 16'h2405, T);
		bus(1'b1, IDX_STATUS, T);
		bus(1'b0, 16'h2405, Z);
		cmp(rdv, Z);
		bus(1'b0, IDX_STATUS, Z);
		cmp(rdv, 32'h100);
		bus(1'b1, IDX_DWELL, 32'h2);
		bus(1'b1, IDX_TORQ, 32'h100);
		bus(1'b0, IDX_DWELL, Z);
		cmp(rdv, 32'h2);
		bus(1'b1, IDX_SW_SPD, SS);
		bus(1'b1, IDX_ZERO_SPD, ZS);
		env(Z, Z, Z, T, Z, T);
		run(M_35, 1'b0, 1'b0, Z, 1'b1, 1'b0, 32'h3E8);
		run(8'h05, 1'b0, 1'b0, Z, 1'b0, 1'b1, T);
		env(Z, Z, Z, T, Z, T);
		run(M_34, 1'b1, 1'b0, ZS, 1'b1, 1'b0, 32'h400);
		env(Z, Z, Z, T, Z, T);
		run(M_33, 1'b1, 1'b1, ZS, 1'b1, 1'b0, 32'h3E0);
		env(32'h3F2, 32'h44C, Z, T, Z, T);
		run(M_24, 1'b1, 1'b0, SS, 1'b1, 1'b0, 32'h3F2);
		env(32'h3C0, 32'h3DE, Z, T, Z, T);
		run(M_28, 1'b1, 1'b1, SS, 1'b1, 1'b0, 32'h3DD);
		env(32'h3CA, 32'h3DE, Z, T, Z, T);
		run(M_14, 1'b1, 1'b1, SS, 1'b1, 1'b0, 32'h3C0);
		env(32'h3CA, 32'h3DE, Z, T, Z, T);
		run(M_11, 1'b1, 1'b1, SS, 1'b1, 1'b0, 32'h3C0);
		// inverted polarity: the raw switch reads low above 0x3C9
		env(Z, 32'h3CA, Z, T, Z, T);
		run(M_12, 1'b1, 1'b1, SS, 1'b1, 1'b0, 32'h3C0);
		env(Z, 32'h3CA, Z, T, Z, T);
		run(M_13, 1'b1, 1'b1, SS, 1'b1, 1'b0, 32'h3C0);
		env(32'h3C0, 32'h3F2, Z, T, Z, T);
		run(M_14, 1'b1, 1'b1, SS, 1'b1, 1'b0, 32'h3A0);
		env(32'h3F2, 32'h41A, 32'h3CA, T, Z, T);
		run(M_14, 1'b1, 1'b1, SS, 1'b1, 1'b0, 32'h3E0);
		env(Z, Z, 32'h3D4, T, Z, T);
		run(M_N5, 1'b1, 1'b1, SS, 1'b0, 1'b1, T);
		env(Z, Z, Z, 32'h3ED, Z, T);
		run(M_N6, 1'b1, 1'b0, SS, 1'b0, 1'b1, T);
		env(32'h3F2, 32'h44C, Z, T, Z, T);
		run(M_N6, 1'b1, 1'b0, SS, 1'b1, 1'b0, 32'h3F2);
		env(Z, Z, Z, T, 32'h3DE, T);
		run(M_N3, 1'b1, 1'b1, SS, 1'b1, 1'b0, 32'h3DE);
		env(Z, Z, Z, T, 32'h3DE, T);
		run(M_N1, 1'b1, 1'b1, SS, 1'b1, 1'b0, 32'h3E0);
		env(Z, Z, Z, T, Z, 32'h3F2);
		run(M_N4, 1'b1, 1'b0, SS, 1'b1, 1'b0, 32'h3F2);
		env(Z, Z, Z, T, Z, 32'h3F2);
		run(M_N2, 1'b1, 1'b0, SS, 1'b1, 1'b0, 32'h3E0);
		bus(1'b0, IDX_CTRL, Z);
		cmp(rdv, 32'hFE);
		// reset in the middle of a stopper run
		env(Z, Z, Z, T, 32'h3DE, T);
		bus(1'b1, IDX_CTRL, {24'h000001, M_N3});
		repeat (3) @(posedge core_clk_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		#1;
		cmp({29'h0, busy, err, done}, Z);
		cmp({31'h0, motion.move}, Z);
		bus(1'b0, IDX_TORQ, Z);
		cmp(rdv, 32'h64);
		bus(1'b0, IDX_CTRL, Z);
		cmp(rdv, Z);
		close_out();
	end
endmodule
